// File: hw/pmc_cfg.svh
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

// Configuration memory layout, words per cell
`define PMC_PTS 5
`define PMC_CELL_WORDS 32
`define PMC_PT_WORDS 4
`define PMC_CTRL_A 20
`define PMC_CTRL_B 21

// Byte addresses of the shared registers
`define PMC_SWM_BASE 12'h800
`define PMC_SWM_MASK 12'hf00
`define PMC_SIG_ADDR 12'h900
`define PMC_STAT_ADDR 12'h904
`define PMC_PIN_ADDR 12'h908
`define PMC_FUSE_ADDR 12'h90c

// Reset values
`define PMC_SIG_RST 16'h0000

// Control word A fields
`define PMC_OR_LSB 0
`define PMC_XOR_LSB 5
`define PMC_DSEL_LSB 7
`define PMC_MODE_LSB 9
`define PMC_CLK_LSB 12
`define PMC_CE_BIT 14
`define PMC_AR_LSB 15
`define PMC_AP_BIT 17
`define PMC_OREG_BIT 18
`define PMC_FBREG_BIT 19
`define PMC_FOLD_LSB 20
`define PMC_CAS_BIT 23

// Control word B fields
`define PMC_OE_LSB 0
`define PMC_OEIDX_LSB 3
`define PMC_OD_BIT 7
`define PMC_GCLR_LSB 8

// Switch matrix select word, and the term code of the control word A clock select
`define PMC_SWM_EN_BIT 6
`define PMC_CLK_TERM 2'h3

`endif

// File: hw/pmc_pkg.sv
package pmc_pkg;

   typedef enum logic [2:0] {PMC_FF_D, PMC_FF_T, PMC_FF_JK, PMC_FF_SR, PMC_FF_LATCH}
      pmc_ff_mode_t;
   typedef enum logic [1:0] {PMC_X_LOW, PMC_X_HIGH, PMC_X_TERM} pmc_xor_sel_t;
   typedef enum logic [1:0] {PMC_D_XOR, PMC_D_TERM, PMC_D_PIN} pmc_dsel_t;
   typedef enum logic [1:0] {PMC_AR_OFF, PMC_AR_GCLR, PMC_AR_TERM, PMC_AR_BOTH} pmc_ar_sel_t;
   typedef enum logic [2:0] {PMC_OE_OFF, PMC_OE_ON, PMC_OE_DED, PMC_OE_DED_N, PMC_OE_PIN,
      PMC_OE_CELL} pmc_oe_sel_t;

endpackage

// File: hw/pmc_macrocell_block.sv
`timescale 1ns/1ps
// Functional notes
// - Five product terms per cell, each sees global and regional bus inputs.
// - OR gate sums own terms, cascade input extends sum to 40 terms.
// - Cascade chains link adjacent cells, each chain up to 40 terms.
// - XOR second input is a product term or constant high or low.
// - T storage XORs data with the stored state; JK storage takes K from term 1.
// - Storage data from XOR output, dedicated product term or I/O pin.
// - Storage is D, T, JK, SR flip-flop or latch transparent while clock high.
// - Clock from three global clock pins or a product term, rising edge.
// - Global clock with term enable ignores edges while enable term is low.
// - Async reset from global clear, a term, their OR, or off.
// - Async preset from a product term or off, no global preset.
// - Output and buried feedback each independently registered or combinational.
// - Output enable from true or inverted enable pins, I/O pins or cells.
// - I/O may be input, output or bidirectional; logic stays usable as input.
// - Global bus holds pins and all feedbacks; switch matrix picks 40.
// - Each cell drives an inverted term onto a sixteen-cell regional bus.
// - Each I/O pin offers an open-drain output mode for wired-OR lines.
// - Four dedicated inputs serve as reset or output enable, the first three also as clock, chosen per cell.
// - 16-bit user signature stays readable after the security fuse is set.
// - Reset initialises all registers; outputs then follow configured polarity.
`include "pmc_cfg.svh"

module pmc_macrocell_block
   import pmc_pkg::*;
#(
   parameter int CELLS = 16,
   parameter int SWM_INPUTS = 40,
   parameter int CHAIN_CELLS = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] ded_in,
   input wire logic [CELLS-1:0] io_in,
   output logic [CELLS-1:0] io_out,
   output logic [CELLS-1:0] io_oe
);

   localparam int NIN = SWM_INPUTS + CELLS;

   // ****************************************************************
   // Parameter checks
   // ****************************************************************
   if (CELLS < 1 || CELLS > 16 || SWM_INPUTS < 1 || SWM_INPUTS > 64 || NIN > 64 ||
       CHAIN_CELLS < 1) begin : bad_params
      $error("pmc_macrocell_block: unsupported parameter values");
   end

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [CELLS*`PMC_CELL_WORDS-1:0][31:0] cfg;
      logic [SWM_INPUTS-1:0][6:0] swm;
      logic [15:0] sig;
      logic fuse;
      logic [2:0][3:0] ded_s;
      logic [2:0][CELLS-1:0] io_s;
      logic [3:0] ded_f;
      logic [CELLS-1:0] io_f;
      logic [CELLS-1:0] q;
      logic [CELLS-1:0] clk_lv;
      logic [CELLS-1:0] fb;
      logic [CELLS-1:0] fold;
      logic [CELLS-1:0] out;
      logic [CELLS-1:0] oe;
      logic [31:0] rdata;
      logic ready;
      logic err;
   } pmc_state_t;

   localparam pmc_state_t ST_RST = '{sig: `PMC_SIG_RST, default: '0};

   pmc_state_t r;
   pmc_state_t n;
   logic [CELLS-1:0] ar_v;
   logic [CELLS-1:0] ap_v;
   logic [CELLS-1:0] d_v;
   logic [CELLS-1:0] eg_v;
   logic [CELLS-1:0] lv_v;
   logic [CELLS-1:0] blk_v;

   // Byte-lane merge for APB writes
   function automatic logic [31:0] pmc_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] stb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (stb[i]) begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   always_comb begin
      logic [63:0] gb;
      logic [SWM_INPUTS-1:0] mi;
      logic [NIN-1:0] ain;
      logic [CELLS-1:0] sum;
      logic [4:0] pt;
      logic [31:0] ca;
      logic [31:0] cb;
      logic [31:0] rv;
      logic [31:0] wd;
      logic [63:0] tm;
      logic [63:0] cm;
      logic xo, dv, lv, eg, ar, ap, gc, nq, dat, oe, hit, wr, in_cfg, in_swm, cas;
      int b;
      gb = '0;
      mi = '0;
      ain = '0;
      sum = '0;
      pt = '0;
      ca = '0;
      cb = '0;
      rv = '0;
      wd = '0;
      tm = '0;
      cm = '0;
      {xo, dv, lv, eg, ar, ap, gc, nq, dat, oe, hit, wr, in_cfg, in_swm, cas} = '0;
      b = 0;
      n = r;
      ar_v = '0;
      ap_v = '0;
      d_v = '0;
      eg_v = '0;
      lv_v = '0;
      blk_v = '0;

      // Pin synchronisers, a change counts once stages two and three agree
      n.ded_s = {r.ded_s[1:0], ded_in};
      n.io_s = {r.io_s[1:0], io_in};
      n.ded_f = ((r.ded_s[1] ~^ r.ded_s[2]) & r.ded_s[2]) | ((r.ded_s[1] ^ r.ded_s[2]) & r.ded_f);
      n.io_f = ((r.io_s[1] ~^ r.io_s[2]) & r.io_s[2]) | ((r.io_s[1] ^ r.io_s[2]) & r.io_f);

      // Global bus and switch matrix
      gb = 64'({r.fb, r.io_f, r.ded_f});
      for (int i = 0; i < SWM_INPUTS; i++) begin
         mi[i] = r.swm[i][`PMC_SWM_EN_BIT] & gb[r.swm[i][5:0]];
      end
      ain = {r.fold, mi};

      // Cells in chain order, so each cascade input is ready when used
      for (int c = 0; c < CELLS; c++) begin
         b = c * `PMC_CELL_WORDS;
         ca = r.cfg[b + `PMC_CTRL_A];
         cb = r.cfg[b + `PMC_CTRL_B];
         for (int p = 0; p < `PMC_PTS; p++) begin
            tm = {r.cfg[b + p*`PMC_PT_WORDS + 1], r.cfg[b + p*`PMC_PT_WORDS]};
            cm = {r.cfg[b + p*`PMC_PT_WORDS + 3], r.cfg[b + p*`PMC_PT_WORDS + 2]};
            pt[p] = (&(~tm[NIN-1:0] | ain)) & (&(~cm[NIN-1:0] | ~ain));
         end
         sum[c] = |(pt & ca[`PMC_OR_LSB +: `PMC_PTS]);
         if (ca[`PMC_CAS_BIT] && (c % CHAIN_CELLS) != 0) begin
            sum[c] = sum[c] | cas;
         end
         cas = sum[c]; // Cascade input of the next cell

         // XOR polarity stage
         unique case (pmc_xor_sel_t'(ca[`PMC_XOR_LSB +: 2]))
            PMC_X_LOW: xo = sum[c];
            PMC_X_HIGH: xo = ~sum[c];
            PMC_X_TERM: xo = sum[c] ^ pt[0];
            default: xo = sum[c];
         endcase

         // Storage data source
         unique case (pmc_dsel_t'(ca[`PMC_DSEL_LSB +: 2]))
            PMC_D_XOR: dv = xo;
            PMC_D_TERM: dv = pt[1];
            PMC_D_PIN: dv = r.io_f[c];
            default: dv = xo;
         endcase

         // Clock select, edge detect and term clock enable
         if (ca[`PMC_CLK_LSB +: 2] == `PMC_CLK_TERM) begin
            lv = pt[2];
         end else begin
            lv = r.ded_f[ca[`PMC_CLK_LSB +: 2]];
         end
         n.clk_lv[c] = lv;
         eg = lv & ~r.clk_lv[c];
         blk_v[c] = ca[`PMC_CE_BIT] & (ca[`PMC_CLK_LSB +: 2] != `PMC_CLK_TERM) & ~pt[2];
         if (blk_v[c]) begin
            eg = 1'b0;
         end

         // Asynchronous reset and preset sources
         gc = r.ded_f[cb[`PMC_GCLR_LSB +: 2]];
         unique case (pmc_ar_sel_t'(ca[`PMC_AR_LSB +: 2]))
            PMC_AR_OFF: ar = 1'b0;
            PMC_AR_GCLR: ar = gc;
            PMC_AR_TERM: ar = pt[3];
            PMC_AR_BOTH: ar = gc | pt[3];
         endcase
         ap = ca[`PMC_AP_BIT] & pt[4];

         // Storage element, reset over preset over clocked update
         nq = r.q[c];
         if (ar) begin
            nq = 1'b0;
         end else if (ap) begin
            nq = 1'b1;
         end else begin
            unique case (pmc_ff_mode_t'(ca[`PMC_MODE_LSB +: 3]))
               PMC_FF_D: nq = eg ? dv : r.q[c];
               PMC_FF_T: nq = eg ? (r.q[c] ^ dv) : r.q[c];
               PMC_FF_JK: nq = eg ? ((dv & ~r.q[c]) | (~pt[1] & r.q[c])) : r.q[c];
               PMC_FF_SR: nq = (eg & dv) | (~(eg & pt[1]) & r.q[c]);
               PMC_FF_LATCH: nq = lv ? dv : r.q[c];
               default: nq = r.q[c];
            endcase
         end
         n.q[c] = nq;

         // Buried feedback, foldback and output path
         n.fb[c] = ca[`PMC_FBREG_BIT] ? nq : xo;
         if (ca[`PMC_FOLD_LSB +: 3] < 3'(`PMC_PTS)) begin
            n.fold[c] = ~pt[ca[`PMC_FOLD_LSB +: 3]];
         end else begin
            n.fold[c] = 1'b0;
         end
         dat = ca[`PMC_OREG_BIT] ? nq : xo;

         // Output enable, off leaves the cell logic running as an input
         unique case (pmc_oe_sel_t'(cb[`PMC_OE_LSB +: 3]))
            PMC_OE_OFF: oe = 1'b0;
            PMC_OE_ON: oe = 1'b1;
            PMC_OE_DED: oe = r.ded_f[cb[`PMC_OEIDX_LSB +: 2]];
            PMC_OE_DED_N: oe = ~r.ded_f[cb[`PMC_OEIDX_LSB +: 2]];
            PMC_OE_PIN: oe = gb[4 + int'(cb[`PMC_OEIDX_LSB +: 4])];
            PMC_OE_CELL: oe = gb[4 + CELLS + int'(cb[`PMC_OEIDX_LSB +: 4])];
            default: oe = 1'b0;
         endcase
         n.out[c] = ~cb[`PMC_OD_BIT] & dat;
         n.oe[c] = oe & (~cb[`PMC_OD_BIT] | ~dat);

         ar_v[c] = ar;
         ap_v[c] = ap;
         d_v[c] = dv;
         eg_v[c] = eg;
         lv_v[c] = lv;
      end

      // APB address decode
      in_cfg = ~paddr[11] && (int'(paddr[10:7]) < CELLS) && (paddr[6:2] <= 5'(`PMC_CTRL_B));
      in_swm = ((paddr & `PMC_SWM_MASK) == `PMC_SWM_BASE) && (int'(paddr[7:2]) < SWM_INPUTS);
      if (in_cfg) begin
         hit = 1'b1;
         rv = r.cfg[paddr[10:2]];
      end else if (in_swm) begin
         hit = 1'b1;
         rv = 32'(r.swm[paddr[7:2]]);
      end else begin
         unique case (paddr)
            `PMC_SIG_ADDR: begin
               hit = 1'b1;
               rv = 32'(r.sig);
            end
            `PMC_STAT_ADDR: begin
               hit = 1'b1;
               rv = 32'(r.q);
            end
            `PMC_PIN_ADDR: begin
               hit = 1'b1;
               rv = 32'({r.ded_f, r.io_f});
            end
            `PMC_FUSE_ADDR: begin
               hit = 1'b1;
               rv = 32'(r.fuse);
            end
            default: hit = 1'b0;
         endcase
      end

      // Access answers one cycle after the first access cycle
      n.ready = psel & penable & ~r.ready;
      n.err = psel & penable & ~r.ready & ~hit;
      if (psel && penable && !r.ready) begin
         n.rdata = (r.fuse && (in_cfg || in_swm)) ? '0 : rv;
      end

      // Writes land on the edge that samples pready high
      wr = psel & penable & pwrite & r.ready;
      wd = pmc_merge(rv, pwdata, pstrb);
      if (wr && in_cfg) begin
         n.cfg[paddr[10:2]] = wd;
      end
      if (wr && in_swm) begin
         n.swm[paddr[7:2]] = wd[6:0];
      end
      if (wr && paddr == `PMC_SIG_ADDR) begin
         n.sig = wd[15:0];
      end
      if (wr && paddr == `PMC_FUSE_ADDR && pstrb[0] && pwdata[0]) begin
         n.fuse = 1'b1;
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= ST_RST;
      end else begin
         r <= n;
      end
   end

   // Outputs straight from state flops
   assign prdata = r.rdata;
   assign pready = r.ready;
   assign pslverr = r.err;
   assign io_out = r.out;
   assign io_oe = r.oe;

   // ****************************************************************
   // Assertions on cell zero and the APB port
   // ****************************************************************
   pmc_ff_mode_t mode0;
   logic od0;
   assign mode0 = pmc_ff_mode_t'(r.cfg[`PMC_CTRL_A][`PMC_MODE_LSB +: 3]);
   assign od0 = r.cfg[`PMC_CTRL_B][`PMC_OD_BIT];

   default clocking pmc_cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   clear_forces_low_a: assert property (ar_v[0] |=> !r.q[0])
      else $error("async reset did not clear cell");
   preset_forces_high_a: assert property (ap_v[0] && !ar_v[0] |=> r.q[0])
      else $error("async preset did not set cell");
   edge_capture_a: assert property (
      eg_v[0] && !ar_v[0] && !ap_v[0] && mode0 == PMC_FF_D |=> r.q[0] == $past(d_v[0]))
      else $error("rising edge did not capture data");
   enable_blocks_edge_a: assert property (
      blk_v[0] && !ar_v[0] && !ap_v[0] && mode0 != PMC_FF_LATCH |=> $stable(r.q[0]))
      else $error("edge taken while clock enable low");
   toggle_flips_a: assert property (
      eg_v[0] && d_v[0] && !ar_v[0] && !ap_v[0] && mode0 == PMC_FF_T
      |=> r.q[0] != $past(r.q[0]))
      else $error("toggle mode did not flip");
   latch_flows_a: assert property (
      lv_v[0] && !ar_v[0] && !ap_v[0] && mode0 == PMC_FF_LATCH |=> r.q[0] == $past(d_v[0]))
      else $error("latch not transparent while clock high");
   drain_never_high_a: assert property ($past(od0) && io_oe[0] |-> !io_out[0])
      else $error("open drain pin driven high");
   signature_read_a: assert property (
      psel && penable && !pwrite && paddr == `PMC_SIG_ADDR && pready |-> prdata == 32'(r.sig))
      else $error("signature read mismatch");
   fuse_hides_cfg_a: assert property (
      r.fuse && psel && penable && !pwrite && pready && !paddr[11] |-> prdata == 32'h0)
      else $error("configuration readable with fuse set");
   ready_one_cycle_a: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");

endmodule

// File: verification/pmc_board_model.sv
`timescale 1ns/1ps
// ************************************************************
// Board logic around the pins
// ************************************************************
module pmc_board_model #(
   parameter int CELLS = 16
) (
   input wire logic [CELLS-1:0] io_out,
   input wire logic [CELLS-1:0] io_oe,
   input wire logic [CELLS-1:0] ext_en,
   input wire logic [CELLS-1:0] ext_val,
   input wire logic [3:0] ded_val,
   output logic [CELLS-1:0] io_in,
   output logic [3:0] ded_in
);
   // Wire level: device drive wins, then board drive, else the pull-up
   always_comb begin
      for (int i = 0; i < CELLS; i++) begin
         io_in[i] = io_oe[i] ? io_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
      end
   end
   // Dedicated pins come straight from board drivers
   assign ded_in = ded_val;
endmodule

// File: verification/programmable_logic_macrocell_tb.sv
`timescale 1ns/1ps
// ************************************************************
// Bench for one macrocell block over APB and pins
// ************************************************************
module programmable_logic_macrocell_tb;
   logic pclk, presetn, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdq;
   logic [3:0] pstrb, ded_in, ded_val;
   logic pready, pslverr, rerr;
   logic [15:0] io_in, io_out, io_oe, ext_en, ext_val;
   int bad_count = 0;
   int cmp_count = 0;

   pmc_macrocell_block i_pmc_macrocell_block (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ded_in(ded_in), .io_in(io_in),
      .io_out(io_out), .io_oe(io_oe));
   pmc_board_model i_pmc_board_model (.io_out(io_out), .io_oe(io_oe), .ext_en(ext_en),
      .ext_val(ext_val), .ded_val(ded_val), .io_in(io_in), .ded_in(ded_in));

   // 50 MHz clock
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // Prints the counts and the verdict, then stops
   task automatic give_verdict;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Compares one value and reports a mismatch
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // One APB transfer; waits for pready under a bound
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         bad_count++;
         $display("[ERR] pready expected 1 seen %b", pready);
         give_verdict();
      end
      rdq = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(nm, rdq, exp);
   endtask

   // Pin sync plus the cell register take up to five edges
   task automatic set_ded(input int k, input logic v);
      @(posedge pclk);
      ded_val[k] <= v;
      repeat (6) @(posedge pclk);
   endtask

   task automatic pulse(input int k);
      set_ded(k, 1'b1);
      set_ded(k, 1'b0);
   endtask

   task automatic pin(input logic q, input logic oe);
      chk("io_out0", {31'h0, io_out[0]}, {31'h0, q});
      chk("io_oe0", {31'h0, io_oe[0]}, {31'h0, oe});
   endtask

   // Main sequence
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite} = 3'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hf;
      ded_val = 4'h0;
      ext_en = 16'h0000;
      ext_val = 16'h0000;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      pin(1'b0, 1'b0);
      rd("signature", 12'h900, 32'h0000_0000);
      rd("storage", 12'h904, 32'h0000_0000);
      wr(12'h900, 32'h1234_a5a5);
      rd("signature", 12'h900, 32'h0000_a5a5);
      rd("unmapped", 12'ha00, 32'h0000_0000);
      chk("pslverr", {31'h0, rerr}, 32'h1);
      // Switch 0 takes dedicated pin 3, switch 1 pin 2; term 0 is switch 0
      wr(12'h800, 32'h0000_0043);
      wr(12'h804, 32'h0000_0042);
      wr(12'h000, 32'h0000_0001);
      rd("term0", 12'h000, 32'h0000_0001);
      chk("pslverr", {31'h0, rerr}, 32'h0);
      rd("switch1", 12'h804, 32'h0000_0042);
      // Combinational output, enable always on
      wr(12'h050, 32'h0000_0001);
      wr(12'h054, 32'h0000_0001);
      set_ded(3, 1'b1);
      pin(1'b1, 1'b1);
      wr(12'h050, 32'h0000_0021);
      repeat (3) @(posedge pclk);
      pin(1'b0, 1'b1);
      // D register on dedicated clock 0, registered output
      wr(12'h050, 32'h0004_0001);
      repeat (3) @(posedge pclk);
      pin(1'b0, 1'b1);
      pulse(0);
      pin(1'b1, 1'b1);
      rd("storage", 12'h904, 32'h0000_0001);
      // Global clear from dedicated pin 1 acts with no clock
      wr(12'h054, 32'h0000_0101);
      wr(12'h050, 32'h0004_8001);
      set_ded(1, 1'b1);
      pin(1'b0, 1'b1);
      set_ded(1, 1'b0);
      pin(1'b0, 1'b1);
      // Clock enable from term 2 (pin 2)
      wr(12'h020, 32'h0000_0002);
      wr(12'h050, 32'h0004_4001);
      pulse(0);
      pin(1'b0, 1'b1);
      set_ded(2, 1'b1);
      pulse(0);
      pin(1'b1, 1'b1);
      // Toggle mode with sum term high
      wr(12'h050, 32'h0004_0201);
      pulse(0);
      pin(1'b0, 1'b1);
      pulse(0);
      pin(1'b1, 1'b1);
      // Preset from term 4 (empty term is high)
      set_ded(3, 1'b0);
      wr(12'h050, 32'h0004_0001);
      pulse(0);
      pin(1'b0, 1'b1);
      wr(12'h050, 32'h0006_0001);
      repeat (3) @(posedge pclk);
      pin(1'b1, 1'b1);
      // Open drain: low drives, high releases to the pull-up
      wr(12'h050, 32'h0000_0001);
      wr(12'h054, 32'h0000_0081);
      set_ded(3, 1'b1);
      pin(1'b0, 1'b0);
      // Released pin needs the synchroniser to settle; dedicated pin 2 is still high
      repeat (4) @(posedge pclk);
      rd("pins", 12'h908, 32'h000c_ffff);
      set_ded(3, 1'b0);
      pin(1'b0, 1'b1);
      // Board drives pin 1 low; cell 1 stays an input
      @(posedge pclk);
      ext_en[1] <= 1'b1;
      repeat (6) @(posedge pclk);
      rd("pins", 12'h908, 32'h0004_fffc);
      // Latch passes data while clock pin 0 is high, holds while it is low
      wr(12'h054, 32'h0000_0001);
      wr(12'h050, 32'h0004_0801);
      repeat (3) @(posedge pclk);
      pin(1'b1, 1'b1);
      set_ded(0, 1'b1);
      pin(1'b0, 1'b1);
      set_ded(3, 1'b1);
      pin(1'b1, 1'b1);
      set_ded(0, 1'b0);
      set_ded(3, 1'b0);
      pin(1'b1, 1'b1);
      // Storage takes the pin level: pull-up first, then the board drives it low
      wr(12'h054, 32'h0000_0000);
      wr(12'h050, 32'h0000_0100);
      pulse(0);
      rd("storage", 12'h904, 32'h0000_0001);
      @(posedge pclk);
      ext_en[0] <= 1'b1;
      pulse(0);
      rd("storage", 12'h904, 32'h0000_0000);
      // Cell 1 takes the sum of cell 0 through its cascade input
      wr(12'h050, 32'h0000_0001);
      wr(12'h0d0, 32'h0080_0000);
      set_ded(3, 1'b1);
      pulse(0);
      rd("storage", 12'h904, 32'h0000_0003);
      // Fuse hides configuration, not the signature
      wr(12'h90c, 32'h0000_0001);
      rd("ctrl_a", 12'h050, 32'h0000_0000);
      rd("signature", 12'h900, 32'h0000_a5a5);
      give_verdict();
   end
endmodule
